/* hdl/addr_mode_pkg.sv */
// Constants and types shared by the addressing-mode decoder and executor.
// Assumes an 8-bit datapath, a 16-bit program counter and byte-wide stores.
package addr_mode_pkg;

   localparam logic [15:0] PC_RESET      = 16'h0000;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam logic [7:0]  PTR_STEP      = 8'h01;

   // Opcode encodings of the instructions this unit decodes.
   localparam logic [7:0]  OPC_COPY_DD   = 8'h01;
   localparam logic [7:0]  OPC_IND_SRC   = 8'h02;
   localparam logic [7:0]  OPC_IND_DST   = 8'h03;
   localparam logic [7:0]  OPC_COPY_XRD  = 8'h04;
   localparam logic [7:0]  OPC_COPY_XWR  = 8'h05;
   localparam logic [7:0]  OPC_REG_XRD   = 8'h06;
   localparam logic [7:0]  OPC_REG_XWR   = 8'h07;
   localparam logic [7:0]  OPC_ADD_DD    = 8'h08;

   // Instruction lengths in bytes.
   localparam logic [1:0]  LEN_ONE       = 2'h1;
   localparam logic [1:0]  LEN_TWO       = 2'h2;
   localparam logic [1:0]  LEN_THREE     = 2'h3;

   typedef enum logic [2:0] {
      MODE_NONE,
      MODE_DIR_DIR,
      MODE_IND_SRC,
      MODE_IND_DST,
      MODE_IDX_RAM_RD,
      MODE_IDX_RAM_WR,
      MODE_IDX_REG_RD,
      MODE_IDX_REG_WR
   } addr_mode_t;

endpackage : addr_mode_pkg

/* hdl/decode_if.sv */
// Carries an opcode to the decoder and its decoded mode and length back.
// Assumes both ends run on the same clock; the path is combinational.
`timescale 1ns/1ps
interface decode_if;
   import addr_mode_pkg::*;

   logic [7:0] opcode;
   addr_mode_t mode;
   logic [1:0] length;
   logic       legal;

   modport exec (output opcode, input mode, input length, input legal);
   modport dec  (input opcode, output mode, output length, output legal);
endinterface : decode_if

/* hdl/opcode_decoder.sv */
// Maps an opcode to its addressing mode, byte length and legality.
// Assumes the opcode is stable while the executor reads the result.
`timescale 1ns/1ps
module opcode_decoder (
   decode_if.dec dif
);
   import addr_mode_pkg::*;

   always_comb begin
      dif.mode   = MODE_NONE;
      dif.length = LEN_ONE;
      dif.legal  = 1'b1;
      unique case (dif.opcode)
         OPC_COPY_DD: begin
            dif.mode   = MODE_DIR_DIR;   // [RULE2]
            dif.length = LEN_THREE;      // [RULE3]
         end
         OPC_IND_SRC: begin
            dif.mode   = MODE_IND_SRC;   // [RULE7]
            dif.length = LEN_TWO;        // [RULE7]
         end
         OPC_IND_DST: begin
            dif.mode   = MODE_IND_DST;   // [RULE7]
            dif.length = LEN_TWO;        // [RULE7]
         end
         OPC_COPY_XRD: begin
            dif.mode   = MODE_IDX_RAM_RD;
            dif.length = LEN_TWO;
         end
         OPC_COPY_XWR: begin
            dif.mode   = MODE_IDX_RAM_WR;
            dif.length = LEN_TWO;
         end
         OPC_REG_XRD: begin
            dif.mode   = MODE_IDX_REG_RD;
            dif.length = LEN_TWO;
         end
         OPC_REG_XWR: begin
            dif.mode   = MODE_IDX_REG_WR;
            dif.length = LEN_TWO;
         end
         default: begin
            // An arithmetic opcode asking for two memory operands is refused.
            dif.legal = 1'b0;            // [RULE2]
         end
      endcase
   end

endmodule : opcode_decoder

/* hdl/addr_mode_exec.sv */
// Fetches instructions and executes the copy and indirect transfer modes.
// Assumes program memory, data RAM and register space answer reads
// combinationally from the address outputs within the same cycle.
//
// Operation
// RULE1: Direct-direct copy writes first operand address, reads second.
// RULE2: Direct-direct mode writes RAM and exists only for the copy opcode.
// RULE3: Direct-direct instruction is three bytes; the PC advances by three.
// RULE4: Source indirect reads pointer at operand, loads pointed byte into A.
// RULE5: Destination indirect reads pointer at operand, stores A there.
// RULE6: Both indirect modes increment the stored pointer after the transfer.
// RULE7: Indirect modes only on indirect transfer opcode, two bytes long.
// RULE8: Source indirect targets A; only the pointer is written to memory.
// RULE9: Indexed modes address index plus offset, in RAM or register space.
`timescale 1ns/1ps
module addr_mode_exec (
   input  wire logic        sys_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        en_in,
   input  wire logic [7:0]  code_data_in,
   input  wire logic [7:0]  ram_rdata_in,
   input  wire logic [7:0]  reg_rdata_in,
   input  wire logic [7:0]  acc_in,
   input  wire logic [7:0]  index_in,
   output logic      [15:0] code_addr_out,
   output logic      [7:0]  ram_addr_out,
   output logic      [7:0]  ram_wdata_out,
   output logic             ram_we_out,
   output logic      [7:0]  reg_addr_out,
   output logic      [7:0]  reg_wdata_out,
   output logic             reg_we_out,
   output logic      [7:0]  acc_wdata_out,
   output logic             acc_we_out,
   output logic             done_out,
   output logic             illegal_out
);
   import addr_mode_pkg::*;

   typedef enum logic [2:0] {
      S_OP, S_OP1, S_OP2, S_ADDR, S_PTR, S_DATA, S_INC, S_END
   } state_t;

   typedef struct packed {
      state_t      st;
      logic [15:0] pc;
      logic [7:0]  op;
      logic [7:0]  op1;
      logic [7:0]  op2;
      logic [7:0]  ptr;
      logic [15:0] code_addr;
      logic [7:0]  ram_addr;
      logic [7:0]  ram_wdata;
      logic        ram_we;
      logic [7:0]  reg_addr;
      logic [7:0]  reg_wdata;
      logic        reg_we;
      logic [7:0]  acc_wdata;
      logic        acc_we;
      logic        done;
      logic        bad;
      logic        ill;
   } exec_t;

   exec_t r_r;
   exec_t r_nxt;

   decode_if dif ();

   opcode_decoder u_dec (
      .dif (dif)
   );

   // Index plus offset wraps inside the 256-byte space, as the index does.
   function automatic logic [7:0] idx_addr(input logic [7:0] x,
                                           input logic [7:0] off);
      idx_addr = x + off;
   endfunction : idx_addr

   function automatic logic [15:0] pc_plus(input logic [15:0] pc,
                                           input logic [1:0]  n);
      pc_plus = pc + {14'h0000, n};
   endfunction : pc_plus

   assign dif.opcode = r_r.op;

   always_comb begin
      r_nxt        = r_r;
      r_nxt.ram_we = 1'b0;
      r_nxt.reg_we = 1'b0;
      r_nxt.acc_we = 1'b0;
      r_nxt.done   = 1'b0;
      r_nxt.ill    = 1'b0;
      unique case (r_r.st)
         S_OP: begin
            r_nxt.op        = code_data_in;
            r_nxt.bad       = 1'b0;
            r_nxt.code_addr = pc_plus(r_r.pc, LEN_ONE);
            r_nxt.st        = S_OP1;
         end
         S_OP1: begin
            r_nxt.op1 = code_data_in;
            if (!dif.legal) begin
               r_nxt.bad = 1'b1;                             // [RULE2]
               r_nxt.st  = S_END;
            end else if (dif.length == LEN_THREE) begin
               r_nxt.code_addr = pc_plus(r_r.pc, LEN_TWO);   // [RULE3]
               r_nxt.st        = S_OP2;
            end else begin
               r_nxt.st = S_ADDR;                            // [RULE7]
            end
         end
         S_OP2: begin
            r_nxt.op2 = code_data_in;
            r_nxt.st  = S_ADDR;
         end
         S_ADDR: begin
            r_nxt.st = S_DATA;
            unique case (dif.mode)
               MODE_DIR_DIR: r_nxt.ram_addr = r_r.op2;       // [RULE1]
               MODE_IND_SRC, MODE_IND_DST: begin
                  r_nxt.ram_addr = r_r.op1;                  // [RULE4] [RULE5]
                  r_nxt.st       = S_PTR;
               end
               MODE_IDX_RAM_RD: begin
                  r_nxt.ram_addr = idx_addr(index_in, r_r.op1); // [RULE9]
               end
               MODE_IDX_RAM_WR: begin
                  r_nxt.ram_addr  = idx_addr(index_in, r_r.op1); // [RULE9]
                  r_nxt.ram_wdata = acc_in;
                  r_nxt.ram_we    = 1'b1;
                  r_nxt.st        = S_END;
               end
               MODE_IDX_REG_RD: begin
                  r_nxt.reg_addr = idx_addr(index_in, r_r.op1); // [RULE9]
               end
               MODE_IDX_REG_WR: begin
                  r_nxt.reg_addr  = idx_addr(index_in, r_r.op1); // [RULE9]
                  r_nxt.reg_wdata = acc_in;
                  r_nxt.reg_we    = 1'b1;
                  r_nxt.st        = S_END;
               end
               MODE_NONE: r_nxt.st = S_END;
            endcase
         end
         S_PTR: begin
            r_nxt.ptr      = ram_rdata_in;
            r_nxt.ram_addr = ram_rdata_in;
            if (dif.mode == MODE_IND_DST) begin
               r_nxt.ram_wdata = acc_in;                     // [RULE5]
               r_nxt.ram_we    = 1'b1;                       // [RULE5]
               r_nxt.st        = S_INC;
            end else begin
               r_nxt.st = S_DATA;                            // [RULE4]
            end
         end
         S_DATA: begin
            r_nxt.st = S_END;
            unique case (dif.mode)
               MODE_DIR_DIR: begin
                  r_nxt.ram_addr  = r_r.op1;                 // [RULE1]
                  r_nxt.ram_wdata = ram_rdata_in;
                  r_nxt.ram_we    = 1'b1;                    // [RULE2]
               end
               MODE_IND_SRC: begin
                  // No RAM write here: the accumulator is the only target.
                  r_nxt.acc_wdata = ram_rdata_in;            // [RULE4] [RULE8]
                  r_nxt.acc_we    = 1'b1;                    // [RULE8]
                  r_nxt.st        = S_INC;
               end
               MODE_IDX_REG_RD: begin
                  r_nxt.acc_wdata = reg_rdata_in;            // [RULE9]
                  r_nxt.acc_we    = 1'b1;
               end
               default: begin
                  r_nxt.acc_wdata = ram_rdata_in;            // [RULE9]
                  r_nxt.acc_we    = 1'b1;
               end
            endcase
         end
         S_INC: begin
            // The pointer is bumped only after it has served the transfer.
            r_nxt.ram_addr  = r_r.op1;                       // [RULE6]
            r_nxt.ram_wdata = r_r.ptr + PTR_STEP;            // [RULE6]
            r_nxt.ram_we    = 1'b1;                          // [RULE6]
            r_nxt.st        = S_END;
         end
         S_END: begin
            r_nxt.pc        = pc_plus(r_r.pc, dif.length);   // [RULE3] [RULE7]
            r_nxt.code_addr = pc_plus(r_r.pc, dif.length);
            r_nxt.done      = 1'b1;
            r_nxt.ill       = r_r.bad;                       // [RULE2]
            r_nxt.st        = S_OP;
         end
      endcase
   end

   // Reset wins over a stall, so a frozen block can still be restarted.
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         r_r           <= '0;
         r_r.st        <= S_OP;
         r_r.pc        <= PC_RESET;
         r_r.code_addr <= PC_RESET;
      end else if (en_in) begin
         r_r <= r_nxt;
      end
   end

   assign code_addr_out = r_r.code_addr;
   assign ram_addr_out  = r_r.ram_addr;
   assign ram_wdata_out = r_r.ram_wdata;
   assign ram_we_out    = r_r.ram_we;
   assign reg_addr_out  = r_r.reg_addr;
   assign reg_wdata_out = r_r.reg_wdata;
   assign reg_we_out    = r_r.reg_we;
   assign acc_wdata_out = r_r.acc_wdata;
   assign acc_we_out    = r_r.acc_we;
   assign done_out      = r_r.done;
   // A flop of its own keeps the pin free of gates behind the register.
   assign illegal_out   = r_r.ill;

endmodule : addr_mode_exec

/* sim/addr_mode_exec_properties.sv */
// Checker for the addressing-mode executor, bound to its top module.
// Assumes a single clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module addr_mode_exec_checker (
   input wire logic       sys_clk_in,
   input wire logic       rstn_in,
   input wire logic       en_in,
   input wire logic [7:0] ram_rdata_in,
   input wire logic [7:0] ram_addr_out,
   input wire logic [7:0] ram_wdata_out,
   input wire logic       ram_we_out,
   input wire logic       reg_we_out,
   input wire logic [7:0] acc_wdata_out,
   input wire logic       acc_we_out,
   input wire logic       done_out,
   input wire logic       illegal_out
);
   // A stall stretches pulses, so timing relations are only judged while run.
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in || !en_in);

   property p_ill_quiet;
      illegal_out |-> done_out && !ram_we_out && !$past(ram_we_out);
   endproperty
   a_ill_quiet:
      assert property (p_ill_quiet) else $error("illegal op wrote memory");
   property p_src_inc;
      acc_we_out ##1 ram_we_out |-> ram_addr_out == $past(ram_addr_out, 3)
         && ram_wdata_out == $past(ram_addr_out, 2) + 8'h01;
   endproperty
   a_src_inc:
      assert property (p_src_inc) else $error("source pointer not bumped");
   property p_src_load;
      acc_we_out ##1 ram_we_out |-> $past(acc_wdata_out) ==
         $past(ram_rdata_in, 2) && $past(ram_addr_out, 2) ==
         $past(ram_rdata_in, 3);
   endproperty
   a_src_load:
      assert property (p_src_load) else $error("wrong indirect load");
   property p_dst;
      ram_we_out ##1 ram_we_out |-> $past(ram_addr_out) ==
         $past(ram_rdata_in, 2) &&
         ram_wdata_out == $past(ram_addr_out) + 8'h01;
   endproperty
   a_dst:
      assert property (p_dst) else $error("wrong indirect store");
   property p_dst_done;
      ram_we_out ##1 ram_we_out |=> done_out;
   endproperty
   a_dst_done:
      assert property (p_dst_done) else $error("indirect store not done");
   property p_acc_excl;
      acc_we_out |-> !ram_we_out && !reg_we_out;
   endproperty
   a_acc_excl:
      assert property (p_acc_excl) else $error("memory written with load");
   property p_acc_next;
      acc_we_out |=> done_out != ram_we_out;
   endproperty
   a_acc_next:
      assert property (p_acc_next) else $error("bad step after load");
   property p_reg_done;
      reg_we_out |=> done_out && !reg_we_out;
   endproperty
   a_reg_done:
      assert property (p_reg_done) else $error("register write not done");

   c_src: cover property (acc_we_out ##1 ram_we_out);
   c_dst: cover property (ram_we_out ##1 ram_we_out);
   c_ill: cover property (illegal_out);
endmodule : addr_mode_exec_checker

bind addr_mode_exec addr_mode_exec_checker chk_i (.sys_clk_in, .rstn_in,
   .en_in, .ram_rdata_in, .ram_addr_out, .ram_wdata_out, .ram_we_out,
   .reg_we_out, .acc_wdata_out, .acc_we_out, .done_out, .illegal_out);

/* sim/mem_model.sv */
// Program memory, data RAM and register space seen by the executor.
// Assumes reads answer combinationally and writes land on the clock edge.
`timescale 1ns/1ps
module mem_model (
   input  wire logic        clk_in,
   input  wire logic [15:0] code_addr_in,
   input  wire logic [7:0]  ram_addr_in,
   input  wire logic [7:0]  ram_wdata_in,
   input  wire logic        ram_we_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_we_in,
   output logic      [7:0]  code_data_out,
   output logic      [7:0]  ram_rdata_out,
   output logic      [7:0]  reg_rdata_out
);
   logic [7:0] code [256];
   logic [7:0] ram  [256];
   logic [7:0] regs [256];
   // Only the low byte of the fetch address is decoded; programs stay short.
   assign code_data_out = code[code_addr_in[7:0]];
   assign ram_rdata_out = ram[ram_addr_in];
   assign reg_rdata_out = regs[reg_addr_in];
   always @(posedge clk_in) begin
      if (ram_we_in === 1'b1) ram[ram_addr_in] <= ram_wdata_in;
      if (reg_we_in === 1'b1) regs[reg_addr_in] <= reg_wdata_in;
   end
endmodule : mem_model

/* sim/tb_addr_mode_exec.sv */
// Self-checking bench for the addressing-mode executor.
// Assumes the memory model answers reads in the same cycle.
`timescale 1ns/1ps
module tb_addr_mode_exec;
   import addr_mode_pkg::*;
   logic sys_clk_in, rstn_in, en_in, ram_we_out, reg_we_out;
   logic acc_we_out, done_out, illegal_out;
   logic [7:0] acc_in, index_in, code_data_in, ram_rdata_in, reg_rdata_in;
   logic [7:0] ram_addr_out, ram_wdata_out, reg_addr_out, reg_wdata_out;
   logic [7:0] acc_wdata_out, acc_seen;
   logic [15:0] code_addr_out;
   int n_mismatch = 0;
   int checks = 0;

   addr_mode_exec dut (.sys_clk_in, .rstn_in, .en_in, .code_data_in,
      .ram_rdata_in, .reg_rdata_in, .acc_in, .index_in, .code_addr_out,
      .ram_addr_out, .ram_wdata_out, .ram_we_out, .reg_addr_out,
      .reg_wdata_out, .reg_we_out, .acc_wdata_out, .acc_we_out, .done_out,
      .illegal_out);
   mem_model mem (.clk_in(sys_clk_in), .code_addr_in(code_addr_out),
      .ram_addr_in(ram_addr_out), .ram_wdata_in(ram_wdata_out),
      .ram_we_in(ram_we_out), .reg_addr_in(reg_addr_out),
      .reg_wdata_in(reg_wdata_out), .reg_we_in(reg_we_out),
      .code_data_out(code_data_in), .ram_rdata_out(ram_rdata_in),
      .reg_rdata_out(reg_rdata_in));

   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) begin
      if (acc_we_out === 1'b1) acc_seen <= acc_wdata_out;
   end

   task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // Each test restarts from address zero so expected counters stay simple.
   task boot(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
      rstn_in = 1'b0;
      acc_seen = 8'h00;
      mem.code[0] = b0;
      mem.code[1] = b1;
      mem.code[2] = b2;
      repeat (16) @(negedge sys_clk_in);
      rstn_in = 1'b1;
   endtask : boot

   task go(input int k, input logic [15:0] pc, input logic ill);
      int n;
      n = 0;
      do begin
         @(negedge sys_clk_in);
         n++;
      end while (done_out !== 1'b1 && n < 20);
      chk("cycles", 16'(k), 16'(n));
      chk("pc", pc, code_addr_out);
      chk("illegal", {15'h0000, ill}, {15'h0000, illegal_out});
   endtask : go

   task t_copy;
      mem.ram[7] = 8'h00;
      mem.ram[8] = 8'h5a;
      boot(OPC_COPY_DD, 8'h07, 8'h08);
      go(6, 16'h0003, 1'b0);
      chk("ram7", 16'h005a, {8'h00, mem.ram[7]});
      chk("ram8", 16'h005a, {8'h00, mem.ram[8]});
      $display("test copy finished");
   endtask : t_copy

   task t_indirect;
      mem.ram[8] = 8'hff;
      mem.ram[8'hff] = 8'hc3;
      boot(OPC_IND_SRC, 8'h08, 8'h00);
      go(7, 16'h0002, 1'b0);
      chk("acc", 16'h00c3, {8'h00, acc_seen});
      chk("ptr", 16'h0000, {8'h00, mem.ram[8]});
      chk("ramff", 16'h00c3, {8'h00, mem.ram[8'hff]});
      mem.ram[8] = 8'h20;
      mem.ram[8'h20] = 8'h00;
      acc_in = 8'ha5;
      boot(OPC_IND_DST, 8'h08, 8'h00);
      go(6, 16'h0002, 1'b0);
      chk("ram20", 16'h00a5, {8'h00, mem.ram[8'h20]});
      chk("ptr", 16'h0021, {8'h00, mem.ram[8]});
      $display("test indirect finished");
   endtask : t_indirect

   task t_illegal;
      mem.ram[7] = 8'h11;
      boot(OPC_ADD_DD, 8'h07, 8'h08);
      go(3, 16'h0001, 1'b1);
      chk("ram7", 16'h0011, {8'h00, mem.ram[7]});
      $display("test illegal finished");
   endtask : t_illegal

   task t_indexed;
      index_in = 8'h04;
      acc_in = 8'h66;
      boot(OPC_COPY_XWR, 8'h10, 8'h00);
      go(4, 16'h0002, 1'b0);
      chk("ram14", 16'h0066, {8'h00, mem.ram[8'h14]});
      mem.ram[8'h14] = 8'h99;
      boot(OPC_COPY_XRD, 8'h10, 8'h00);
      go(5, 16'h0002, 1'b0);
      chk("acc ram", 16'h0099, {8'h00, acc_seen});
      boot(OPC_REG_XWR, 8'h10, 8'h00);
      go(4, 16'h0002, 1'b0);
      chk("reg14", 16'h0066, {8'h00, mem.regs[8'h14]});
      boot(OPC_REG_XRD, 8'h10, 8'h00);
      go(5, 16'h0002, 1'b0);
      chk("acc", 16'h0066, {8'h00, acc_seen});
      $display("test indexed finished");
   endtask : t_indexed

   // A stall after the opcode fetch must freeze the fetch address and only
   // delay the copy by the stalled cycles.
   task t_stall;
      mem.ram[9] = 8'h00;
      mem.ram[10] = 8'h3c;
      boot(OPC_COPY_DD, 8'h09, 8'h0a);
      @(negedge sys_clk_in);
      en_in = 1'b0;
      repeat (3) @(negedge sys_clk_in);
      chk("stall pc", 16'h0001, code_addr_out);
      en_in = 1'b1;
      go(5, 16'h0003, 1'b0);
      chk("ram9", 16'h003c, {8'h00, mem.ram[9]});
      $display("test stall finished");
   endtask : t_stall

   task wrap_up;
      $display("comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // The tests need about two hundred cycles; ten times that means a hang.
   initial begin
      repeat (2000) @(posedge sys_clk_in);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      rstn_in = 1'b0;
      en_in = 1'b1;
      acc_in = 8'h00;
      index_in = 8'h00;
      t_copy();
      t_indirect();
      t_illegal();
      t_indexed();
      t_stall();
      wrap_up();
   end
endmodule : tb_addr_mode_exec
